// ### hw/uisl_cfg.svh
`ifndef UISL_CFG_SVH
`define UISL_CFG_SVH
`define UISL_NUM_SRC 8
`define UISL_OFF_RAW 12'h02C
`define UISL_OFF_IER 12'h020
`define UISL_OFF_IDR 12'h024
`define UISL_OFF_IMR 12'h028
`define UISL_OFF_ISC 12'h030
`define UISL_RAW_RESET 8'h02
`define UISL_MASK_RESET 8'h00
`define UISL_PEND_RESET 8'h00
`define UISL_BIT_RX_AVAIL 0
`define UISL_BIT_TX_EMPTY 1
`define UISL_BIT_LINE_STATUS 2
`define UISL_BIT_MODEM_CHANGE 3
`define UISL_BIT_CHAR_TIMEOUT 4
`define UISL_BIT_BUSY 5
`define UISL_BIT_AUTOBAUD_DONE 6
`define UISL_BIT_AUTOBAUD_TIMEOUT 7
`endif

// ### hw/uisl_pkg.sv
package uisl_pkg;
	typedef logic [7:0] uisl_src_t;
	typedef struct packed
	{
		logic autobaud_timeout;
		logic autobaud_done;
		logic busy;
		logic char_timeout;
		logic modem_change;
		logic line_status;
		logic tx_empty;
		logic rx_avail;
	} uisl_src_s;
	typedef struct packed
	{
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} uisl_apb_req_s;
	typedef struct packed
	{
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} uisl_apb_rsp_s;
endpackage

// ### hw/uisl_src_bit.sv
`timescale 1ns/1ns
`default_nettype none
// one interrupt source: raw, mask state and pending flag
module uisl_src_bit #(
	parameter logic RAW_RESET = 1'b0
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic event_level,
	input wire logic enable_set,
	input wire logic disable_set,
	input wire logic clear_set,
	output logic raw,
	output logic mask_bit,
	output logic pending
);
	typedef struct packed
	{
		logic raw;
		logic mask_bit;
		logic pending;
	} uisl_bit_s;
	uisl_bit_s state;
	uisl_bit_s next_state;
	always_comb
	begin
		next_state = state;
		next_state.raw = event_level; // [RULE4] [RULE6]
		if (enable_set)
			next_state.mask_bit = 1'b1; // [RULE12]
		else if (disable_set)
			next_state.mask_bit = 1'b0; // [RULE13]
		if (clear_set)
			next_state.pending = 1'b0; // [RULE8]
		if (event_level && state.mask_bit)
			next_state.pending = 1'b1; // [RULE7] set wins over clear
		if (!state.mask_bit)
			next_state.pending = 1'b0; // [RULE7] masked reads zero
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state <= {RAW_RESET, 1'b0, 1'b0}; // [RULE3] [RULE5] [RULE9]
		else
			state <= next_state;
	end
	assign raw = state.raw;
	assign mask_bit = state.mask_bit;
	assign pending = state.pending;
endmodule
`default_nettype wire

// ### hw/uisl_top.sv
// Overview of operation
// RULE1: mask-state register shows one enable bit per source, bits 7 down to 0.
// RULE2: bits 31 to 8 of every interrupt register read zero, ignore writes.
// RULE3: after reset all mask-state bits are zero, all sources masked.
// RULE4: raw status at 0x2C shows each source event regardless of mask.
// RULE5: raw tx-empty bit resets to one, other raw bits to zero.
// RULE6: raw rx-available bit is one while received data is available.
// RULE7: pending bit is one only when source signalled and source enabled.
// RULE8: writing one to a pending bit clears it, others unchanged.
// RULE9: all pending bits reset to zero, including tx-empty.
// RULE10: character timeout reports at pending bit 4 when enabled.
// RULE11: modem status at pending bit 3, line status at bit 2.
// RULE12: writing one to enable register sets mask-state bit; zero ignored.
// RULE13: writing one to disable register clears mask-state bit.
// RULE14: one level interrupt output high while any pending bit is set.
`include "uisl_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module uisl_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire uisl_pkg::uisl_src_s src_event,
	output logic irq
);
	import uisl_pkg::*;
	typedef struct packed
	{
		logic [31:0] prdata;
		logic pslverr;
		logic irq;
	} uisl_top_s;
	uisl_top_s state;
	uisl_top_s next_state;
	uisl_src_t raw;
	uisl_src_t mask_bits;
	uisl_src_t pending;
	uisl_src_t enable_set;
	uisl_src_t disable_set;
	uisl_src_t clear_set;
	uisl_src_t event_vec;
	logic wr_access;
	logic rd_setup;
	logic addr_ok;
	// per-bit reset value of the raw flags, taken one bit at a time
	localparam uisl_src_t RAW_RST = `UISL_RAW_RESET;
	assign event_vec = src_event;
	assign wr_access = psel && penable && pwrite;
	assign rd_setup = psel && !penable && !pwrite;
	always_comb
	begin
		case (paddr)
			`UISL_OFF_IER, `UISL_OFF_IDR, `UISL_OFF_IMR, `UISL_OFF_RAW, `UISL_OFF_ISC:
				addr_ok = 1'b1;
			default:
				addr_ok = 1'b0;
		endcase
	end
	// only bits 7:0 are decoded; upper write bits are dropped [RULE2]
	assign enable_set = (wr_access && paddr == `UISL_OFF_IER) ? pwdata[7:0] : 8'h00; // [RULE12]
	assign disable_set = (wr_access && paddr == `UISL_OFF_IDR) ? pwdata[7:0] : 8'h00; // [RULE13]
	assign clear_set = (wr_access && paddr == `UISL_OFF_ISC) ? pwdata[7:0] : 8'h00; // [RULE8]
	genvar i;
	generate
		for (i = 0; i < `UISL_NUM_SRC; i++)
		begin : g_src
			uisl_src_bit #(
				.RAW_RESET(RAW_RST[i])
			) u_bit (
				.pclk(pclk),
				.presetn(presetn),
				.event_level(event_vec[i]),
				.enable_set(enable_set[i]),
				.disable_set(disable_set[i]),
				.clear_set(clear_set[i]),
				.raw(raw[i]),
				.mask_bit(mask_bits[i]),
				.pending(pending[i])
			); // [RULE10] [RULE11]
		end
	endgenerate
	always_comb
	begin
		next_state = state;
		next_state.irq = |pending; // [RULE14]
		if (rd_setup)
		begin
			next_state.prdata = 32'h0000_0000;
			case (paddr)
				`UISL_OFF_IMR:
					next_state.prdata = {24'h00_0000, mask_bits}; // [RULE1] [RULE2]
				`UISL_OFF_RAW:
					next_state.prdata = {24'h00_0000, raw}; // [RULE4]
				`UISL_OFF_ISC:
					next_state.prdata = {24'h00_0000, pending}; // [RULE7]
				default:
					next_state.prdata = 32'h0000_0000;
			endcase
		end
		if (psel && !penable)
			next_state.pslverr = !addr_ok;
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state <= '0;
		else
			state <= next_state;
	end
	assign prdata = state.prdata;
	assign pslverr = state.pslverr && psel && penable;
	assign pready = 1'b1;
	assign irq = state.irq;
endmodule
`default_nettype wire

// ### tb/uisl_chk.sv
`timescale 1ns/1ns
`default_nettype none
module uisl_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic irq,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire uisl_pkg::uisl_src_s src_event
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic r = psel & penable & ~pwrite;
	wire logic ok = paddr inside {12'h020, 12'h024, 12'h028, 12'h02C, 12'h030};
	sequence s_w(x, v); psel && penable && pwrite && paddr == x && pwdata[7:0] == v; endsequence
	property p_rsv; r |-> prdata[31:8] == 0; endproperty
	a_rsv: assert property (p_rsv) else $error("rsv");
	property p_zero; r && (!ok || paddr < 12'h028) |-> prdata == 0; endproperty
	a_zero: assert property (p_zero) else $error("zero");
	property p_err; psel && !penable |=> pslverr == !$past(ok); endproperty
	a_err: assert property (p_err) else $error("err");
	property p_irq; r && paddr == 12'h030 |-> irq == (prdata != 0); endproperty
	a_irq: assert property (p_irq) else $error("irq");
	property p_raw; r && paddr == 12'h02C && $past(presetn, 2) |-> prdata == $past(src_event, 2); endproperty
	a_raw: assert property (p_raw) else $error("raw");
	property p_en; s_w(12'h020, 8'hFF) ##0 src_event == 8'hFF [*2] |-> ##2 irq; endproperty
	a_en: assert property (p_en) else $error("en");
	property p_clr; s_w(12'h030, 8'hFF) ##0 src_event == 0 |-> ##2 !irq; endproperty
	a_clr: assert property (p_clr) else $error("clr");
	property p_dis; s_w(12'h024, 8'hFF) |-> ##3 !irq; endproperty
	a_dis: assert property (p_dis) else $error("dis");
endmodule
bind uisl_top uisl_chk u_chk (.*);
`default_nettype wire

// ### tb/uisl_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CK(n, e, s) begin checks++; if ((s) !== (e)) begin errors++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module uisl_top_tb;
	import uisl_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	uisl_src_s src_event = 0;
	int errors = 0, checks = 0;
	logic [7:0] r, m, c, k;
	logic se;
	always #2 pclk = ~pclk;
	uisl_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.src_event, .irq);
	function automatic logic [7:0] pend(logic [7:0] e, n, x);
		return e & n & ~x;
	endfunction
	task automatic tally_and_finish();
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic xf(logic w, logic [11:0] a, logic [31:0] d);
		int n = 0;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do
			@(posedge pclk);
		while (pready !== 1'b1 && ++n < 20);
		if (pready !== 1'b1)
		begin
			errors++;
			tally_and_finish();
		end
		rd = prdata;
		se = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task automatic rc(string s, logic [11:0] a, logic [31:0] e);
		xf(0, a, 0);
		`CK(s, e, rd)
	endtask
	initial
	begin
		void'($urandom(32'h95daece6));
		// transmitter idle at start: raw copy keeps its reset pattern
		src_event = 8'h02;
		repeat (10) @(posedge pclk);
		presetn <= 1;
		rc("raw", 12'h02C, 2);
		rc("mask", 12'h028, 0);
		`CK("err", 1'b0, se)
		rc("pend", 12'h030, 0);
		rc("gap", 12'h034, 0);
		`CK("err", 1'b1, se)
		for (int i = 0; i < 30; i++)
		begin
			r = i ? $urandom : 8'hFF;
			m = i ? $urandom : 8'hFF;
			k = i ? $urandom : 8'hFF;
			c = $urandom;
			src_event <= r;
			rc("pend", 12'h030, 0);
			rc("raw", 12'h02C, r);
			xf(1, 12'h020, {24'hFFFFFF, m});
			xf(1, 12'h020, 0);
			rc("mask", 12'h028, m);
			xf(1, 12'h024, c);
			rc("mask", 12'h028, m & ~c);
			rc("pend", 12'h030, pend(r, m, c));
			`CK("irq", |pend(r, m, c), irq)
			src_event <= 0;
			xf(1, 12'h030, {24'hFFFFFF, k});
			rc("pend", 12'h030, pend(r, m & ~c, k));
			`CK("irq", |pend(r, m & ~c, k), irq)
			xf(1, 12'h024, 8'hFF);
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire
